// *** common/sti_cfg.svh ***
// Constants for the start frame delimiter timestamp indicator
// How it works
// - The transmit timestamp event fires only when a valid delimiter is seen on the transmit signals.
// - The receive timestamp event fires only when a valid delimiter is seen on the receive signals.
// - Each event carries no payload; its assertion alone means delimiter detected.
// - Each direction recognises the delimiter by the framing of the selected interface variant.
// - Recognition is selectable for the 4-bit, 8-bit, 10G, 40G and 100G interface variants.
// - Events are defined only in full-duplex operation and are suppressed otherwise.
`ifndef STI_CFG_SVH
`define STI_CFG_SVH

// Narrow interface symbols
`define STI_NIB_PRE      4'h5
`define STI_NIB_SFD      4'hd
`define STI_BYTE_PRE     8'h55
`define STI_BYTE_SFD     8'hd5
// Wide interface control character that opens a frame
`define STI_CHAR_START   8'hfb

// Control flag positions for narrow variants
`define STI_EN_BIT       0
`define STI_ER_BIT       1

// Lane positions on the 64-bit word
`define STI_LANE_LO      0
`define STI_LANE_MID_LO  3
`define STI_LANE_MID_HI  4
`define STI_LANE_HI      7

// Reset values and synchronizer depth
`define STI_NIBBLE_RST   4'h0
`define STI_TOGGLE_RST   1'b0
`define STI_SYNC_DEPTH   2

`endif

// *** common/sti_pkg.sv ***
// Types for the start frame delimiter timestamp indicator
package sti_pkg;

  // Interface variant served by the delimiter detectors
  typedef enum logic [2:0] {
    STI_MODE_MII,
    STI_MODE_GMII,
    STI_MODE_XGMII,
    STI_MODE_XLGMII,
    STI_MODE_CGMII
  } sti_mode_e;

  // One interface word: the 8-bit variant uses data[7:0], the 4-bit variant data[3:0], ctrl[0]=enable, ctrl[1]=error
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  ctrl;
  } sti_xmii_s;

  // Detector result for one word
  typedef struct packed {
    logic hit;
    logic startMid;
  } sti_det_s;

endpackage : sti_pkg

// *** hw/sti_sfd_timestamp_indicator.sv ***
// Delimiter detectors raising transmit and receive timestamp events
`timescale 1ns/1ps
`default_nettype none
`include "sti_cfg.svh"

module sti_sfd_timestamp_indicator
  import sti_pkg::*;
(
  // System domain
  input  wire logic      clk,
  input  wire logic      rst,
  // Configuration, system domain levels
  input  wire sti_mode_e variantSel,
  input  wire logic      fullDuplex,
  // Link domain
  input  wire logic      linkClk,
  input  wire sti_xmii_s txXmiiIn,
  input  wire sti_xmii_s rxXmiiIn,
  output var  sti_xmii_s txXmiiOut,
  output var  sti_xmii_s rxXmiiOut,
  // Events on the link clock
  output var  logic      txTimestampEvent,
  output var  logic      rxTimestampEvent,
  // Events carried over to the system clock
  output var  logic      sysTxTimestampEvent,
  output var  logic      sysRxTimestampEvent
);

  localparam int NDIR = 2;

  // Delimiter recognition for one word of the selected variant
  function automatic sti_det_s detectSfd(
    input sti_mode_e mode,
    input sti_xmii_s cur,
    input sti_xmii_s prev,
    input logic      startMid
  );
    sti_det_s res;
    res = '0;
    case (mode)
      STI_MODE_MII: begin
        res.hit = cur.ctrl[`STI_EN_BIT] && prev.ctrl[`STI_EN_BIT]
                  && !cur.ctrl[`STI_ER_BIT]
                  && (cur.data[3:0] == `STI_NIB_SFD)
                  && (prev.data[3:0] == `STI_NIB_PRE);
      end
      STI_MODE_GMII: begin
        res.hit = cur.ctrl[`STI_EN_BIT] && prev.ctrl[`STI_EN_BIT]
                  && !cur.ctrl[`STI_ER_BIT]
                  && (cur.data[7:0] == `STI_BYTE_SFD)
                  && (prev.data[7:0] == `STI_BYTE_PRE);
      end
      STI_MODE_XGMII, STI_MODE_XLGMII, STI_MODE_CGMII: begin
        // Start in the low lane puts the delimiter in the top lane of the same word
        res.hit = cur.ctrl[`STI_LANE_LO]
                  && (cur.data[`STI_LANE_LO*8 +: 8] == `STI_CHAR_START)
                  && !cur.ctrl[`STI_LANE_HI]
                  && (cur.data[`STI_LANE_HI*8 +: 8] == `STI_BYTE_SFD);
        // The 10G variant may start mid word; the delimiter then lands in the next word
        if (mode == STI_MODE_XGMII) begin
          if (startMid && !cur.ctrl[`STI_LANE_MID_LO]
              && (cur.data[`STI_LANE_MID_LO*8 +: 8] == `STI_BYTE_SFD)) begin
            res.hit = 1'b1;
          end
          res.startMid = cur.ctrl[`STI_LANE_MID_HI]
                         && (cur.data[`STI_LANE_MID_HI*8 +: 8] == `STI_CHAR_START);
        end
      end
      default: begin
        res = '0;
      end
    endcase
    return res;
  endfunction : detectSfd

  // ---------------- Link domain reset ----------------
  logic [`STI_SYNC_DEPTH-1:0] linkRstSync_q;
  logic                       linkRst;

  // Asynchronous assert, release aligned to the link clock
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkRstSync_q <= '1;
    end else begin
      linkRstSync_q <= {linkRstSync_q[`STI_SYNC_DEPTH-2:0], 1'b0};
    end
  end
  assign linkRst = linkRstSync_q[`STI_SYNC_DEPTH-1];

  // ---------------- Configuration crossing ----------------
  sti_mode_e modeMeta_q;
  sti_mode_e modeStage_q;
  sti_mode_e modeHold_q;
  sti_mode_e modeSync_q;
  logic      duplexMeta_q;
  logic      duplexSync_q;

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      modeMeta_q  <= STI_MODE_MII;
      modeStage_q <= STI_MODE_MII;
      modeHold_q  <= STI_MODE_MII;
    end else begin
      modeMeta_q  <= variantSel;
      modeStage_q <= modeMeta_q;
      modeHold_q  <= modeStage_q;
    end
  end

  // Code taken only once two samples agree, so bit skew never reaches the detectors
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      modeSync_q <= STI_MODE_MII;
    end else if (modeHold_q == modeStage_q) begin
      modeSync_q <= modeHold_q;
    end
  end

  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      duplexMeta_q <= 1'b0;
      duplexSync_q <= 1'b0;
    end else begin
      duplexMeta_q <= fullDuplex;
      duplexSync_q <= duplexMeta_q;
    end
  end

  // ---------------- Per-direction detectors ----------------
  sti_xmii_s linkIn    [NDIR];
  sti_xmii_s inMeta_q  [NDIR];
  sti_xmii_s inSync_q  [NDIR];
  sti_xmii_s prev_q    [NDIR];
  logic      startMid_q[NDIR];
  logic      event_q   [NDIR];
  logic      toggle_q  [NDIR];
  sti_det_s  det       [NDIR];

  // Index 0 is the transmit direction, 1 the receive direction
  assign linkIn[0] = txXmiiIn;
  assign linkIn[1] = rxXmiiIn;

  // System side of the event crossing
  logic [NDIR-1:0] togMeta_q;
  logic [NDIR-1:0] togSync_q;
  logic [NDIR-1:0] togSeen_q;
  logic [NDIR-1:0] sysEvent_q;

  genvar d;
  generate
    for (d = 0; d < NDIR; d++) begin : g_dir

      // Pins pass two flops before recognition
      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          inMeta_q[d] <= '0;
          inSync_q[d] <= '0;
        end else begin
          inMeta_q[d] <= linkIn[d];
          inSync_q[d] <= inMeta_q[d];
        end
      end

      assign det[d] = detectSfd(modeSync_q, inSync_q[d], prev_q[d], startMid_q[d]);

      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          prev_q[d]     <= '0;
          startMid_q[d] <= 1'b0;
        end else begin
          prev_q[d]     <= inSync_q[d];
          startMid_q[d] <= det[d].startMid;
        end
      end

      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          event_q[d] <= 1'b0;
        end else begin
          event_q[d] <= det[d].hit && duplexSync_q;
        end
      end

      // Toggle hands each event to the system clock
      // Two events toggling within one system sample cancel out and give no system pulse
      always_ff @(posedge linkClk or posedge linkRst) begin
        if (linkRst) begin
          toggle_q[d] <= `STI_TOGGLE_RST;
        end else if (det[d].hit && duplexSync_q) begin
          toggle_q[d] <= !toggle_q[d];
        end
      end

      // Two flops then edge detect on the system clock
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          togMeta_q[d]  <= `STI_TOGGLE_RST;
          togSync_q[d]  <= `STI_TOGGLE_RST;
          togSeen_q[d]  <= `STI_TOGGLE_RST;
          sysEvent_q[d] <= 1'b0;
        end else begin
          togMeta_q[d]  <= toggle_q[d];
          togSync_q[d]  <= togMeta_q[d];
          togSeen_q[d]  <= togSync_q[d];
          sysEvent_q[d] <= togSync_q[d] ^ togSeen_q[d];
        end
      end
    end
  endgenerate

  assign txTimestampEvent    = event_q[0];
  assign rxTimestampEvent    = event_q[1];
  assign txXmiiOut           = prev_q[0];
  assign rxXmiiOut           = prev_q[1];
  assign sysTxTimestampEvent = sysEvent_q[0];
  assign sysRxTimestampEvent = sysEvent_q[1];

endmodule : sti_sfd_timestamp_indicator
`default_nettype wire

// *** testbench/sti_sfd_props.sv ***
// Port assertions for the delimiter timestamp indicator
`timescale 1ns/1ps
`default_nettype none
module sti_sfd_props
  import sti_pkg::*;
(
  // System domain
  input wire logic      clk,
  input wire logic      rst,
  input wire sti_mode_e variantSel,
  input wire logic      fullDuplex,
  // Link domain
  input wire logic      linkClk,
  input wire sti_xmii_s txXmiiIn,
  input wire sti_xmii_s rxXmiiIn,
  input wire sti_xmii_s txXmiiOut,
  input wire sti_xmii_s rxXmiiOut,
  input wire logic      txTimestampEvent,
  input wire logic      rxTimestampEvent,
  // Events on the system clock
  input wire logic      sysTxTimestampEvent,
  input wire logic      sysRxTimestampEvent
);
  function automatic logic dlm(sti_xmii_s w);
    return w.data[7:0] == 8'hd5 || w.data[3:0] == 4'hd || w.data[63:56] == 8'hd5
      || w.data[31:24] == 8'hd5;
  endfunction : dlm

  // Link edges since reset, saturating once the data pipe holds fresh words
  logic [2:0] linkAge_q = 3'd0;
  always @(posedge linkClk) begin
    if (rst)
      linkAge_q <= 3'd0;
    else if (linkAge_q != 3'd5)
      linkAge_q <= linkAge_q + 3'd1;
  end

  AST_TX_DELIM: assert property (@(posedge linkClk) disable iff (rst)
    txTimestampEvent |-> dlm(txXmiiOut)) else $error("tx event without delimiter");
  AST_RX_DELIM: assert property (@(posedge linkClk) disable iff (rst)
    rxTimestampEvent |-> dlm(rxXmiiOut)) else $error("rx event without delimiter");
  AST_DUPLEX: assert property (@(posedge linkClk) disable iff (rst)
    txTimestampEvent || rxTimestampEvent |-> fullDuplex) else $error("event in half duplex");
  AST_TX_PASS: assert property (@(posedge linkClk) disable iff (rst)
    linkAge_q == 3'd5 |-> txXmiiOut == $past(txXmiiIn, 3)) else $error("tx data altered");
  AST_RX_PASS: assert property (@(posedge linkClk) disable iff (rst)
    linkAge_q == 3'd5 |-> rxXmiiOut == $past(rxXmiiIn, 3)) else $error("rx data altered");
  AST_SYS_TX_PULSE: assert property (@(posedge clk) disable iff (rst)
    sysTxTimestampEvent |=> !sysTxTimestampEvent) else $error("sys tx pulse too long");
  AST_SYS_RX_PULSE: assert property (@(posedge clk) disable iff (rst)
    sysRxTimestampEvent |=> !sysRxTimestampEvent) else $error("sys rx pulse too long");
  AST_NARROW_OK: assert property (@(posedge linkClk) disable iff (rst)
    txTimestampEvent && variantSel inside {STI_MODE_MII, STI_MODE_GMII}
    |-> txXmiiOut.ctrl[1:0] == 2'b01) else $error("narrow event on bad word");
endmodule : sti_sfd_props

bind sti_sfd_timestamp_indicator sti_sfd_props u_props (.clk, .rst, .variantSel,
  .fullDuplex, .linkClk, .txXmiiIn, .rxXmiiIn, .txXmiiOut, .rxXmiiOut, .txTimestampEvent,
  .rxTimestampEvent, .sysTxTimestampEvent, .sysRxTimestampEvent);
`default_nettype wire

// *** testbench/sti_link_partner.sv ***
// Far-side source of link words, one frame start per request
`timescale 1ns/1ps
`default_nettype none
module sti_link_partner
  import sti_pkg::*;
(
  // Requests from the bench
  input  wire logic      linkClk,
  input  wire logic      go,
  input  wire sti_mode_e mode,
  input  wire logic      err,
  input  wire logic      mid,
  // Word on the link
  output var  sti_xmii_s word
);
  logic [1:0] step_q = 2'd0;
  function automatic sti_xmii_s frm(logic second);
    sti_xmii_s w;
    w.data = {8{8'h55}};
    w.ctrl = 8'h00;
    if (mode == STI_MODE_MII || mode == STI_MODE_GMII) begin
      w.data[7:0] = second ? (mode == STI_MODE_MII ? 8'h0d : 8'hd5) : 8'h55;
      w.ctrl = {6'h00, err & second, 1'b1};
    end else if (mid) begin
      w.data = second ? {{4{8'h55}}, 8'hd5, {3{8'h55}}} : {{3{8'h55}}, 8'hfb, {4{8'h07}}};
      w.ctrl = second ? 8'h00 : 8'h1f;
    end else begin
      w.data = second ? {8'hd5, {6{8'h55}}, 8'hfb} : {8{8'h07}};
      w.ctrl = second ? 8'h01 : 8'hff;
    end
    return w;
  endfunction : frm

  initial word = '0;
  always @(posedge linkClk) begin
    if (step_q == 2'd3)
      step_q <= go ? 2'd3 : 2'd0;
    else if (step_q != 2'd0 || go)
      step_q <= step_q + 2'd1;
  end
  // Idle words keep changing so nothing stale looks valid
  always @(posedge linkClk) begin
    if (step_q == 2'd1 || step_q == 2'd2)
      word <= frm(step_q[1]);
    else
      word <= '{data: ~word.data, ctrl: 8'h00};
  end
endmodule : sti_link_partner
`default_nettype wire

// *** testbench/sti_sfd_timestamp_indicator_bench.sv ***
// Bench for the delimiter timestamp indicator
`timescale 1ns/1ps
`default_nettype none
module sti_sfd_timestamp_indicator_bench
  import sti_pkg::*;
;
  typedef struct {sti_mode_e m; logic e; logic f; logic x; int n;} sti_row_s;
  logic      clk = 0, linkClk = 0, rst = 1, fd = 1, go = 0, err = 0, mid = 0, txOff = 0;
  logic      tE, rE, sT, sR;
  sti_mode_e mode = STI_MODE_MII;
  sti_xmii_s word;
  int        nT, nR, nST, nSR, n_mismatch, num_checks;
  sti_row_s  rows [11] = '{'{STI_MODE_MII, 0, 1, 0, 1}, '{STI_MODE_GMII, 0, 1, 0, 1},
    '{STI_MODE_XGMII, 0, 1, 0, 1}, '{STI_MODE_XLGMII, 0, 1, 0, 1},
    '{STI_MODE_CGMII, 0, 1, 0, 1}, '{STI_MODE_XGMII, 0, 1, 1, 1},
    '{STI_MODE_CGMII, 0, 1, 1, 0}, '{STI_MODE_MII, 1, 1, 0, 0}, '{STI_MODE_GMII, 1, 1, 0, 0},
    '{STI_MODE_GMII, 0, 0, 0, 0}, '{STI_MODE_XLGMII, 0, 0, 0, 0}};

  sti_sfd_timestamp_indicator uut (.clk, .rst, .variantSel(mode), .fullDuplex(fd), .linkClk,
    .txXmiiIn(txOff ? sti_xmii_s'('0) : word), .rxXmiiIn(word), .txXmiiOut(), .rxXmiiOut(),
    .txTimestampEvent(tE),
    .rxTimestampEvent(rE), .sysTxTimestampEvent(sT), .sysRxTimestampEvent(sR));
  sti_link_partner partner (.linkClk, .go, .mode, .err, .mid, .word);

  initial forever #5 clk = ~clk;
  initial begin
    #17;
    forever #40 linkClk = ~linkClk;
  end
  always @(posedge linkClk) begin
    if (tE === 1'b1) nT++;
    if (rE === 1'b1) nR++;
  end
  always @(posedge clk) begin
    if (sT === 1'b1) nST++;
    if (sR === 1'b1) nSR++;
  end

  task automatic chk(int got, int exp);
    num_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chk

  task automatic run(sti_row_s r, logic hit);
    int t0, r0, s0, q0;
    mode <= r.m;
    err <= r.e;
    fd <= r.f;
    mid <= r.x;
    repeat (40) @(posedge clk);
    {t0, r0, s0, q0} = {nT, nR, nST, nSR};
    go <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= hit;
    repeat (48) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    chk(nT - t0, txOff ? 0 : r.n);
    chk(nR - r0, r.n);
    chk(nST - s0, txOff ? 0 : r.n);
    chk(nSR - q0, r.n);
  endtask : run

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #60000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) run(rows[i], 1'b0);
    // Reset held across the whole frame drops the event, then the block recovers
    run('{STI_MODE_CGMII, 0, 1, 0, 0}, 1'b1);
    run(rows[1], 1'b0);
    // Frame on the receive side only: the transmit event must stay quiet
    txOff <= 1'b1;
    run(rows[0], 1'b0);
    report_and_stop();
  end
endmodule : sti_sfd_timestamp_indicator_bench
`default_nettype wire
